// ===== verilog/mrpf_pkg.sv
package mrpf_pkg;

    // ------------------------------------------------------------
    // post-filter selection codes
    // ------------------------------------------------------------
    localparam logic [2:0] MRPF_SEL_NONE = 3'h0;
    localparam logic [2:0] MRPF_SEL_AVG16 = 3'h1;
    localparam logic [2:0] MRPF_SEL_40MS = 3'h2;
    localparam logic [2:0] MRPF_SEL_50MS = 3'h3;
    localparam logic [2:0] MRPF_SEL_60MS = 3'h4;

    // first-stage selection codes
    localparam logic MRPF_STAGE_SINC5AVG = 1'b0;
    localparam logic MRPF_STAGE_SINC3 = 1'b1;

    // ------------------------------------------------------------
    // block lengths; the 40/50/60 ms ones derived from the nominal first-stage rate
    // ------------------------------------------------------------
    localparam int MRPF_FIRST_RATE_SPS = 1200;
    localparam int MRPF_SETTLE_40_MS = 40;
    localparam int MRPF_SETTLE_50_MS = 50;
    localparam int MRPF_SETTLE_60_MS = 60;
    localparam logic [6:0] MRPF_N_AVG16 = 7'h10;
    localparam logic [6:0] MRPF_N_40MS = 7'(MRPF_SETTLE_40_MS * MRPF_FIRST_RATE_SPS / 1000);
    localparam logic [6:0] MRPF_N_50MS = 7'(MRPF_SETTLE_50_MS * MRPF_FIRST_RATE_SPS / 1000);
    localparam logic [6:0] MRPF_N_60MS = 7'(MRPF_SETTLE_60_MS * MRPF_FIRST_RATE_SPS / 1000);

    // reciprocal scaling for the non power-of-two block lengths
    localparam int MRPF_RECIP_SHIFT = 20;
    localparam logic [15:0] MRPF_RECIP_40MS =
        16'(((2 ** MRPF_RECIP_SHIFT) + MRPF_N_40MS / 2) / MRPF_N_40MS);
    localparam logic [15:0] MRPF_RECIP_50MS =
        16'(((2 ** MRPF_RECIP_SHIFT) + MRPF_N_50MS / 2) / MRPF_N_50MS);
    localparam logic [15:0] MRPF_RECIP_60MS =
        16'(((2 ** MRPF_RECIP_SHIFT) + MRPF_N_60MS / 2) / MRPF_N_60MS);
    localparam int MRPF_AVG16_SHIFT = 4;

    // ------------------------------------------------------------
    // decimation limits and rate relation
    // ------------------------------------------------------------
    localparam int MRPF_DEC_MIN = 4;
    localparam int MRPF_DEC_MAX = 1024;
    localparam int MRPF_MOD_OSR = 32;

endpackage

// ===== verilog/mrpf_post_filter.sv
`timescale 1ns/100ps
// Notes on behaviour
// - 40, 50 and 60 ms post filters further filter first-stage output.
// - either sinc3 or sinc5-plus-average may feed the post filter.
// - other decimation values are accepted; notches then move.
// - average-by-16 option, notch placed by decimation value.
// - sinc5-plus-average alone rejects one mains frequency, no post filter.
// - post-filter selection field picks the active post filter.
// - single channel: first result after settling, then once per period.
// - each channel activation waits full settling before first result.
// - later results on a held channel come one output period apart.
// - at decimation 208, 40/50/60 ms give 25.04/20.03/16.69 SPS.
// - average-by-16 at decimation 260 gives 60.1, at 312 50.1 SPS.
// - filter clock is main clock over the clock divider field.
module mrpf_post_filter
    import mrpf_pkg::*;
#(
    parameter int DATA_W = 24,
    parameter int DEC_W = 11,
    parameter int DIV_W = 4
)
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [2:0] post_filter_sel_i,
    input wire logic first_stage_sel_i,
    input wire logic [DEC_W-1:0] decimation_factor_field_i,
    input wire logic [DIV_W-1:0] clock_divider_field_i,
    input wire logic chan_restart_i,
    input wire logic s_valid_i,
    input wire logic signed [DATA_W-1:0] s_data_i,
    output logic s_ready_o,
    output logic m_valid_o,
    output logic signed [DATA_W-1:0] m_data_o,
    input wire logic m_ready_i,
    output logic [31:0] result_period_o,
    output logic cfg_error_o
);

    localparam int ACC_W = DATA_W + 7;
    localparam int PROD_W = ACC_W + 17;

    // refused at elaboration: the accumulator and period widths assume these ranges
    if (DATA_W < 8 || DATA_W > 32 || DEC_W < 11 || DIV_W < 1 || DIV_W > 8)
    begin : g_param_check
        $error("mrpf_post_filter: unsupported parameter values");
    end

    // ------------------------------------------------------------
    // selection decode
    // ------------------------------------------------------------
    logic [6:0] n_sel;
    logic [15:0] recip_sel;
    logic use_post;

    always_comb
    begin
        use_post = 1'b1;
        recip_sel = MRPF_RECIP_40MS;
        unique case (post_filter_sel_i)
            MRPF_SEL_AVG16: n_sel = MRPF_N_AVG16;
            MRPF_SEL_40MS: n_sel = MRPF_N_40MS;
            MRPF_SEL_50MS:
            begin
                n_sel = MRPF_N_50MS;
                recip_sel = MRPF_RECIP_50MS;
            end
            MRPF_SEL_60MS:
            begin
                n_sel = MRPF_N_60MS;
                recip_sel = MRPF_RECIP_60MS;
            end
            default:
            begin
                // codes beyond the table behave as no post filter
                n_sel = 7'h01;
                use_post = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // block accumulator
    // ------------------------------------------------------------
    logic signed [ACC_W-1:0] acc_q, acc_d;
    logic [6:0] cnt_q, cnt_d;
    logic [2:0] sel_q, sel_d;
    logic stage_q, stage_d;
    logic s_fire;
    logic push;
    logic signed [DATA_W-1:0] push_data;
    logic signed [ACC_W-1:0] sum;
    logic signed [PROD_W-1:0] prod;

    assign s_fire = s_valid_i && s_ready_o;

    always_comb
    begin
        acc_d = acc_q;
        cnt_d = cnt_q;
        sel_d = post_filter_sel_i;
        stage_d = first_stage_sel_i;
        push = 1'b0;
        push_data = s_data_i;
        sum = acc_q + ACC_W'(s_data_i);
        prod = PROD_W'(sum) * $signed({1'b0, recip_sel});
        if (chan_restart_i || sel_q != post_filter_sel_i || stage_q != first_stage_sel_i)
        begin
            // a restart drops the partial block, so the next result
            // again needs a full settling period
            acc_d = '0;
            cnt_d = '0;
        end
        else if (s_fire)
        begin
            if (!use_post)
            begin
                push = 1'b1;
                push_data = s_data_i;
            end
            else if (cnt_q == n_sel - 7'h01)
            begin
                // either first stage is averaged the same way
                push = 1'b1;
                acc_d = '0;
                cnt_d = '0;
                if (post_filter_sel_i == MRPF_SEL_AVG16)
                begin
                    push_data = DATA_W'(sum >>> MRPF_AVG16_SHIFT);
                end
                else
                begin
                    push_data = DATA_W'(prod >>> MRPF_RECIP_SHIFT);
                end
            end
            else
            begin
                acc_d = sum;
                cnt_d = cnt_q + 7'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acc_q <= '0;
            cnt_q <= '0;
            sel_q <= MRPF_SEL_NONE;
            stage_q <= MRPF_STAGE_SINC5AVG;
        end
        else
        begin
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            stage_q <= stage_d;
        end
    end

    // ------------------------------------------------------------
    // two-entry output buffer
    // ------------------------------------------------------------
    logic head_v_q, head_v_d, skid_v_q, skid_v_d, ready_q, ready_d;
    logic signed [DATA_W-1:0] head_q, head_d, skid_q, skid_d;
    logic pop;

    assign pop = head_v_q && m_ready_i;

    always_comb
    begin
        head_v_d = head_v_q;
        head_d = head_q;
        skid_v_d = skid_v_q;
        skid_d = skid_q;
        if (pop)
        begin
            head_v_d = skid_v_q;
            head_d = skid_q;
            skid_v_d = 1'b0;
        end
        if (push)
        begin
            if (!head_v_d)
            begin
                head_v_d = 1'b1;
                head_d = push_data;
            end
            else
            begin
                skid_v_d = 1'b1;
                skid_d = push_data;
            end
        end
        // input stalls while the skid slot is taken, so no word is lost
        ready_d = !skid_v_d;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            head_v_q <= 1'b0;
            head_q <= '0;
            skid_v_q <= 1'b0;
            skid_q <= '0;
            ready_q <= 1'b0;
        end
        else
        begin
            head_v_q <= head_v_d;
            head_q <= head_d;
            skid_v_q <= skid_v_d;
            skid_q <= skid_d;
            ready_q <= ready_d;
        end
    end

    assign s_ready_o = ready_q;
    assign m_valid_o = head_v_q;
    assign m_data_o = head_q;

    // ------------------------------------------------------------
    // rate status and decimation check
    // ------------------------------------------------------------
    logic [31:0] period_q, period_d;
    logic err_q, err_d;
    logic dec_ok;

    always_comb
    begin
        // result period in main clock cycles; filter clock is the main
        // clock divided down, and one first-stage sample is 32*dec of it
        period_d = 32'(clock_divider_field_i) * 32'(MRPF_MOD_OSR)
            * 32'(decimation_factor_field_i) * 32'(n_sel);
        // block lengths realise the tabulated rates at decimation 208/260/312
        dec_ok = decimation_factor_field_i[1:0] == 2'h0
            && decimation_factor_field_i >= DEC_W'(MRPF_DEC_MIN)
            && decimation_factor_field_i <= DEC_W'(MRPF_DEC_MAX);
        // out-of-range values still run; the flag reports them only while a post filter is selected
        err_d = use_post && !dec_ok;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            period_q <= '0;
            err_q <= 1'b0;
        end
        else
        begin
            period_q <= period_d;
            err_q <= err_d;
        end
    end

    assign result_period_o = period_q;
    assign cfg_error_o = err_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    sequence s_last_sample;
        s_fire && use_post && !chan_restart_i && sel_q == post_filter_sel_i
            && stage_q == first_stage_sel_i && cnt_q == n_sel - 7'h01;
    endsequence

    sequence s_restart;
        chan_restart_i;
    endsequence

    a_pass_through: assert property (
        (s_fire && !use_post && !chan_restart_i && sel_q == post_filter_sel_i
            && stage_q == first_stage_sel_i && !head_v_q)
        |=> (m_valid_o && m_data_o == $past(s_data_i)))
        else $error("sample not passed through unchanged");

    a_block_end: assert property (
        s_last_sample |=> (cnt_q == 7'h00 && acc_q == '0))
        else $error("block did not close on its last sample");

    a_no_early_result: assert property (
        (push && use_post) |-> (cnt_q == n_sel - 7'h01))
        else $error("post-filter result before full block");

    a_restart_clear: assert property (
        s_restart |=> (cnt_q == 7'h00 && acc_q == '0))
        else $error("restart left filter state behind");

    a_count_bound: assert property (
        (use_post && sel_q == post_filter_sel_i) |-> (cnt_q < n_sel))
        else $error("block counter beyond block length");

    a_out_hold: assert property (
        (m_valid_o && !m_ready_i) |=> (m_valid_o && $stable(m_data_o)))
        else $error("output word changed while stalled");

    a_no_overflow: assert property (
        s_fire |-> !skid_v_q)
        else $error("sample taken with buffer full");

    // expected period, registered view taken through $past; the first cycle after
    // reset release is skipped because the flop still held its reset value there
    logic [31:0] period_exp;

    assign period_exp = 32'(clock_divider_field_i) * 32'(MRPF_MOD_OSR)
        * 32'(decimation_factor_field_i) * 32'(n_sel);

    a_period_calc: assert property (
        $past(nrst_i) |-> (result_period_o == $past(period_exp)))
        else $error("result period does not match configuration");

    a_dec_flag: assert property (
        (use_post && decimation_factor_field_i[1:0] != 2'h0) |=> cfg_error_o)
        else $error("illegal decimation not flagged");

endmodule

// ===== sim/mrpf_sinc_src.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// first-stage sample source
// ------------------------------------------------------------
module mrpf_sinc_src
(
    input wire logic clk_i,
    input wire logic s_ready_i,
    output logic s_valid_o,
    output logic signed [23:0] s_data_o
);
    logic signed [23:0] q[$];
    int gap = 0;
    int idle = 0;
    logic rdy;
    initial
    begin
        s_valid_o = 1'b0;
        s_data_o = 24'h5a5a5a;
        forever
        begin
            // ready is registered, so the level before the edge is what the edge sees
            @(negedge clk_i);
            rdy = s_ready_i;
            @(posedge clk_i);
            if (s_valid_o && rdy && q.size() > 0 && gap == 0)
                s_data_o <= q.pop_front();
            else if (s_valid_o && rdy)
            begin
                s_valid_o <= 1'b0;
                s_data_o <= ~s_data_o;
                idle = 0;
            end
            else if (!s_valid_o && q.size() > 0 && idle >= gap)
            begin
                s_valid_o <= 1'b1;
                s_data_o <= q.pop_front();
            end
            else if (!s_valid_o)
            begin
                // released data toggles so a stale word is never mistaken for a fresh one
                s_data_o <= ~s_data_o;
                idle++;
            end
        end
    end
endmodule

// ===== sim/mains_rejection_post_filter_test.sv
`timescale 1ns/100ps
module mains_rejection_post_filter_test import mrpf_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [2:0] sel = 3'h0;
    logic stage = 1'b0;
    logic [10:0] dec = 11'h0d0;
    logic [3:0] div = 4'h2;
    logic restart = 1'b0;
    logic m_ready = 1'b1;
    logic s_valid, s_ready, m_valid, cerr;
    logic signed [23:0] s_data, m_data;
    logic [31:0] period;
    logic signed [23:0] got[$];
    int n_fail = 0;
    int samples_checked = 0;

    initial
        forever #50 clk = ~clk;

    mrpf_sinc_src src (.clk_i(clk), .s_ready_i(s_ready), .s_valid_o(s_valid), .s_data_o(s_data));
    mrpf_post_filter dut (.clk_i(clk), .nrst_i(nrst), .post_filter_sel_i(sel),
        .first_stage_sel_i(stage), .decimation_factor_field_i(dec), .clock_divider_field_i(div),
        .chan_restart_i(restart), .s_valid_i(s_valid), .s_data_i(s_data), .s_ready_o(s_ready),
        .m_valid_o(m_valid), .m_data_o(m_data), .m_ready_i(m_ready), .result_period_o(period),
        .cfg_error_o(cerr));

    always @(negedge clk)
    begin
        if (m_valid === 1'b1 && m_ready === 1'b1)
            got.push_back(m_data);
    end

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic results();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_word(input logic signed [23:0] g, input logic signed [23:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic chk_num(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    function automatic int n_of(input logic [2:0] s);
        case (s)
            MRPF_SEL_AVG16: return 16;
            MRPF_SEL_40MS: return 48;
            MRPF_SEL_50MS: return 60;
            MRPF_SEL_60MS: return 72;
            default: return 1;
        endcase
    endfunction

    // block average of a ramp; non power-of-two lengths use a rounded reciprocal
    function automatic logic signed [23:0] blk(input int n, input int first, input int step);
        longint sum;
        longint r;
        sum = 0;
        for (int i = 0; i < n; i++)
            sum += first + i * step;
        r = ((longint'(1) << 20) + n / 2) / n;
        if (n == 1)
            return 24'(sum);
        if (n == 16)
            return 24'(sum >>> 4);
        return 24'((sum * r) >>> 20);
    endfunction

    task automatic cfg(input logic [2:0] s, input int d, input int v, input logic st,
        input logic err);
        @(posedge clk);
        sel <= s;
        dec <= 11'(d);
        div <= 4'(v);
        stage <= st;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk_num(period, 32'(v * 32 * d * n_of(s)));
        chk_num(32'(cerr), 32'(err));
        got.delete();
    endtask

    task automatic send(input int n, input int first, input int step);
        int k;
        for (int i = 0; i < n; i++)
            src.q.push_back(24'(first + i * step));
        k = 0;
        while ((src.q.size() > 0 || s_valid === 1'b1) && k < 5000)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 5000)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic wait_out(input int n);
        int k;
        k = 0;
        while (got.size() < n && k < 2000)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 2000)
        begin
            n_fail++;
            results();
        end
    endtask

    task automatic run(input logic [2:0] s, input int d, input logic st, input int f, input int p);
        int n;
        n = n_of(s);
        cfg(s, d, 2, st, 1'b0);
        send(2 * n, f, p);
        wait_out(2);
        chk_word(got[0], blk(n, f, p));
        chk_word(got[1], blk(n, f + n * p, p));
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_pass();
        logic [2:0] codes[4] = '{3'h0, 3'h5, 3'h6, 3'h7};
        foreach (codes[c])
        begin
            cfg(codes[c], 210, 1, 1'b0, 1'b0);
            send(3, -5 + c, 7);
            wait_out(3);
            for (int i = 0; i < 3; i++)
                chk_word(got[i], 24'(-5 + c + i * 7));
        end
    endtask

    task automatic t_post();
        run(MRPF_SEL_40MS, 208, 1'b0, -3001, 37);
        run(MRPF_SEL_50MS, 208, 1'b0, 5000, -90);
        run(MRPF_SEL_60MS, 208, 1'b1, -77, 11);
        run(MRPF_SEL_AVG16, 260, 1'b0, -100, 13);
        run(MRPF_SEL_AVG16, 312, 1'b0, 2047, -301);
    endtask

    task automatic t_restart();
        cfg(MRPF_SEL_AVG16, 208, 2, 1'b0, 1'b0);
        send(5, 900, 1);
        @(posedge clk);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        repeat (2) @(posedge clk);
        send(16, -40, 3);
        wait_out(1);
        repeat (40) @(posedge clk);
        chk_num(32'(got.size()), 32'h1);
        chk_word(got[0], blk(16, -40, 3));
    endtask

    task automatic t_cfg_err();
        int d[5] = '{4, 1024, 210, 1028, 0};
        for (int i = 0; i < 5; i++)
            cfg(MRPF_SEL_50MS, d[i], 3, 1'b0, i > 1);
    endtask

    // a held receiver must not cost a word: two are parked, the third waits upstream
    task automatic t_stall();
        cfg(MRPF_SEL_NONE, 208, 2, 1'b1, 1'b0);
        @(posedge clk);
        m_ready <= 1'b0;
        src.gap = 2;
        for (int i = 0; i < 3; i++)
            src.q.push_back(24'(-9 - i));
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk_num(32'(s_ready), 32'h0);
        chk_num(32'(got.size()), 32'h0);
        @(posedge clk);
        m_ready <= 1'b1;
        wait_out(3);
        for (int i = 0; i < 3; i++)
            chk_word(got[i], 24'(-9 - i));
        src.gap = 0;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        t_pass();
        t_post();
        t_restart();
        t_cfg_err();
        t_stall();
        results();
    end
endmodule
